// *** ecms_filter.sv ***
// input debounce: a new level is taken once it has held for the set time
`timescale 1ns/1ps
module ecms_filter (
	input wire logic sys_clk,
	input wire logic reset,
	input wire logic msTick,
	input wire logic [15:0] filtMs,
	input wire logic rawIn,
	output logic filtOut
);
	logic [15:0] held_r;
	wire elapsed = (held_r >= filtMs);

	// a setting of zero passes the input after one clock
	always_ff @(posedge sys_clk)
	begin
		if (reset)
		begin
			filtOut <= 1'b0;
			held_r <= 16'h0000;
		end
		else if (rawIn == filtOut)
			held_r <= 16'h0000;
		else if (elapsed)
		begin
			filtOut <= rawIn;
			held_r <= 16'h0000;
		end
		else if (msTick)
			held_r <= held_r + 16'h0001;
	end
endmodule

// *** ecms_host.sv ***
// serial host model: sends requests and collects reply bytes
`timescale 1ns/1ps
module ecms_host #(
	parameter int BAUD_DIV = 16
) (
	input wire logic sys_clk,
	output logic rxd,
	input wire logic txd,
	input wire logic txEn
);
	logic [7:0] got [$];
	initial rxd = 1'b1;
	function automatic logic [15:0] crcOf(input logic [7:0] q [$]);
		logic [15:0] c;
		c = 16'hffff;
		foreach (q[i])
		begin
			c = c ^ {8'h00, q[i]};
			for (int k = 0; k < 8; k++)
				c = c[0] ? ((c >> 1) ^ 16'ha001) : (c >> 1);
		end
		return c;
	endfunction
	// fields in order, crc low byte first
	task automatic sendReq(input logic [7:0] ad, input logic [7:0] fn, input logic [15:0] ra,
		input logic [15:0] rv, input bit bad);
		logic [7:0] q [$];
		logic [15:0] c;
		q = {ad, fn, ra[15:8], ra[7:0], rv[15:8], rv[7:0]};
		c = crcOf(q) ^ (bad ? 16'h0101 : 16'h0000);
		q.push_back(c[7:0]);
		q.push_back(c[15:8]);
		foreach (q[i])
			for (int k = 0; k < 10; k++)
			begin
				@(posedge sys_clk);
				rxd <= (k == 0) ? 1'b0 : (k == 9) ? 1'b1 : q[i][k-1];
				repeat (BAUD_DIV - 1) @(posedge sys_clk);
			end
	endtask
	// samples mid-bit, only while the slave drives the line
	initial
	begin
		logic [7:0] b;
		forever
		begin
			@(posedge sys_clk);
			if (txEn === 1'b1 && txd === 1'b0)
			begin
				repeat (BAUD_DIV / 2) @(posedge sys_clk);
				for (int k = 0; k < 8; k++)
				begin
					repeat (BAUD_DIV) @(posedge sys_clk);
					b[k] = txd;
				end
				repeat (BAUD_DIV) @(posedge sys_clk);
				got.push_back(b);
			end
		end
	end
endmodule

// *** ecms_pkg.sv ***
// constants, types and frame checksum shared by the encoder counter slave
package ecms_pkg;
	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	localparam int CLK_HZ = 125_000_000;
	localparam int BAUD_BPS = 9600;
	localparam int FILT_UNIT_US = 1000;
	localparam int MS_CYCLES = CLK_HZ / 1_000_000 * FILT_UNIT_US;
	localparam int BAUD_DIV = CLK_HZ / BAUD_BPS;
	// 3.5 characters of 11 bit times, rounded up
	localparam int GAP_BITS = 39;
	localparam int GAP_CYCLES = BAUD_DIV * GAP_BITS;
	// ------------------------------------------------------------
	// frame layout
	// ------------------------------------------------------------
	localparam logic [7:0] SLAVE_ADDR = 8'h01;
	localparam logic [7:0] FUNC_READ = 8'h03;
	localparam logic [7:0] FUNC_WRITE = 8'h06;
	localparam int REQ_LEN = 8;
	localparam logic [4:0] HDR_LEN = 5'h03;
	localparam logic [4:0] CRC_LEN = 5'h02;
	localparam logic [15:0] CRC_INIT = 16'hffff;
	localparam logic [15:0] CRC_POLY = 16'ha001;
	localparam logic [15:0] CRC_GOOD = 16'h0000;
	// ------------------------------------------------------------
	// register addresses and values
	// ------------------------------------------------------------
	localparam logic [15:0] REG_MODE = 16'h0000;
	localparam logic [15:0] REG_ENC_LO = 16'h0010;
	localparam logic [15:0] REG_ENC_HI = 16'h0011;
	localparam logic [15:0] REG_CHA_LO = 16'h0020;
	localparam logic [15:0] REG_CHA_HI = 16'h0021;
	localparam logic [15:0] REG_CHB_LO = 16'h0022;
	localparam logic [15:0] REG_CHB_HI = 16'h0023;
	localparam logic [15:0] REG_CLEAR = 16'h0043;
	localparam logic [15:0] REG_PULLUP = 16'h0051;
	localparam logic [15:0] REG_FILT_A = 16'h00b4;
	localparam logic [15:0] REG_FILT_B = 16'h00b5;
	localparam logic [15:0] CLEAR_KEY = 16'h000a;
	localparam logic [15:0] MODE_IND = 16'h0001;
	localparam logic [15:0] PULLUP_ON = 16'h0001;

	typedef enum {TX_IDLE, TX_SEND, TX_WAIT} ecms_tx_t;

	// one byte of the reflected crc-16, lsb first
	function automatic logic [15:0] crc16Byte(input logic [15:0] crc, input logic [7:0] d);
		logic [15:0] c;
		c = crc ^ {8'h00, d};
		for (int i = 0; i < 8; i++)
			c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
		return c;
	endfunction
endpackage

// *** ecms_top.sv ***
// encoder and pulse counter reached as a serial rtu slave
// ------------------------------------------------------------
// Overview of operation
// [R01] host read request: address, 03, start, count, crc
// [R02] read reply: address, function, byte count, data, crc
// [R03] encoder count signed, low word at lower address
// [R04] independent counts unsigned, low word first
// [R05] single register write echoed back unchanged
// [R06] value 000a to register 0043 clears count
// [R07] inputs count correctly up to 50 khz
// [R08] thirty-two bit counts, about two billion range
// [R09] counts kept across power loss and restored
// [R10] mode 0 quadrature, mode 1 two counters
// [R11] mode write takes effect after restart only
// [R12] pull-up register enables input pull-ups
// [R13] per-channel filter time in milliseconds
// [R14] quadrature decoding single resolution only
// [R15] multi-word values low word first
// [R16] crc-16 checked; foreign or bad frames ignored
// ------------------------------------------------------------
//
// Decided for this implementation: the placing of the registers and strobed register access.
`timescale 1ns/1ps
module ecms_top #(
	parameter int MS_CYCLES = ecms_pkg::MS_CYCLES,
	parameter int BAUD_DIV = ecms_pkg::BAUD_DIV,
	parameter int GAP_CYCLES = ecms_pkg::GAP_CYCLES,
	parameter logic [7:0] SLAVE_ADDR = ecms_pkg::SLAVE_ADDR,
	parameter logic [15:0] MAX_READ = 16'h0008,
	parameter int COUNT_W = 32
) (
	input wire logic sys_clk,
	input wire logic reset,
	input wire logic rxd,
	output logic txd,
	output logic txEn,
	input wire logic firstCounterChannel,
	input wire logic secondCounterChannel,
	output logic pullUpEn,
	output logic activeMode,
	input wire logic [15:0] regAddr,
	input wire logic [15:0] regWdata,
	input wire logic regWr,
	input wire logic regRd,
	output logic [15:0] regRdata,
	input wire logic nvRestore,
	input wire logic [15:0] nvRestoreMode,
	input wire logic [COUNT_W-1:0] nvRestoreFirst,
	input wire logic [COUNT_W-1:0] nvRestoreSecond,
	output logic [15:0] nvMode,
	output logic [COUNT_W-1:0] nvFirst,
	output logic [COUNT_W-1:0] nvSecond
);
	import ecms_pkg::*;

	// ------------------------------------------------------------
	// shared register read decode
	// ------------------------------------------------------------
	function automatic logic [15:0] regRead(
		input logic [15:0] a,
		input logic [31:0] c1,
		input logic [31:0] c2,
		input logic [15:0] mode,
		input logic [15:0] pu,
		input logic [15:0] fa,
		input logic [15:0] fb
	);
		logic [15:0] v;
		v = 16'h0000;
		// [R03] encoder word order
		if (a == REG_ENC_LO)
			v = c1[15:0];
		else if (a == REG_ENC_HI)
			v = c1[31:16];
		// [R04] [R15] channel words low first
		else if (a == REG_CHA_LO)
			v = c1[15:0];
		else if (a == REG_CHA_HI)
			v = c1[31:16];
		else if (a == REG_CHB_LO)
			v = c2[15:0];
		else if (a == REG_CHB_HI)
			v = c2[31:16];
		else if (a == REG_MODE)
			v = mode;
		else if (a == REG_PULLUP)
			v = pu;
		else if (a == REG_FILT_A)
			v = fa;
		else if (a == REG_FILT_B)
			v = fb;
		return v;
	endfunction

	localparam int MSW = $clog2(MS_CYCLES);
	localparam logic [MSW-1:0] MS_MAX = MSW'(MS_CYCLES - 1);
	localparam int GW = $clog2(GAP_CYCLES + 1);
	localparam logic [GW-1:0] GAP_MAX = GW'(GAP_CYCLES);
	localparam logic [3:0] REQ_LAST = 4'(REQ_LEN - 1);

	ecms_uart_if uif();
	logic [MSW-1:0] msCnt_r;
	logic [GW-1:0] gapCnt_r;
	logic [7:0] rxBuf_r [REQ_LEN];
	logic [3:0] rxIdx_r;
	logic [15:0] rxCrc_r;
	logic reqPend_r;
	logic [15:0] modeCfg_r;
	logic [15:0] pullUp_r;
	logic [15:0] filtA_r;
	logic [15:0] filtB_r;
	logic activeMode_r;
	logic [COUNT_W-1:0] countFirst_r;
	logic [COUNT_W-1:0] countSecond_r;
	logic [COUNT_W-1:0] snapFirst_r;
	logic [COUNT_W-1:0] snapSecond_r;
	logic aFilt;
	logic bFilt;
	logic aPrev_r;
	logic bPrev_r;
	ecms_tx_t txState_r;
	logic [4:0] txIdx_r;
	logic [4:0] txLen_r;
	logic [7:0] txFunc_r;
	logic [7:0] txCount_r;
	logic [15:0] txStart_r;
	logic [15:0] txCrc_r;

	// ------------------------------------------------------------
	// serial port and input filters
	// ------------------------------------------------------------
	ecms_uart #(.BAUD_DIV(BAUD_DIV)) uUart (
		.sys_clk(sys_clk),
		.reset(reset),
		.rxd(rxd),
		.txd(txd),
		.bus(uif.uart)
	);

	wire msTick = (msCnt_r == MS_MAX);

	// [R13] independent filter per channel
	ecms_filter uFiltA (
		.sys_clk(sys_clk),
		.reset(reset),
		.msTick(msTick),
		.filtMs(filtA_r),
		.rawIn(firstCounterChannel),
		.filtOut(aFilt)
	);

	ecms_filter uFiltB (
		.sys_clk(sys_clk),
		.reset(reset),
		.msTick(msTick),
		.filtMs(filtB_r),
		.rawIn(secondCounterChannel),
		.filtOut(bFilt)
	);

	always_ff @(posedge sys_clk)
	begin
		if (reset || msTick)
			msCnt_r <= '0;
		else
			msCnt_r <= msCnt_r + 1'b1;
	end

	// ------------------------------------------------------------
	// request receive
	// ------------------------------------------------------------
	// a silent line longer than the frame gap restarts the frame
	wire gapHit = (gapCnt_r == GAP_MAX);
	wire rxFirst = gapHit || (rxIdx_r == 4'h0);
	wire [3:0] rxPos = rxFirst ? 4'h0 : rxIdx_r;
	wire rxLast = (rxPos == REQ_LAST);
	wire [15:0] rxCrcNxt = crc16Byte(rxFirst ? CRC_INIT : rxCrc_r, uif.rxData);
	// bytes arriving while we answer are dropped, so the echo source stays put
	wire rxTake = uif.rxValid && (txState_r == TX_IDLE);

	always_ff @(posedge sys_clk)
	begin
		if (reset || uif.rxValid)
			gapCnt_r <= reset ? GAP_MAX : '0;
		else if (!gapHit)
			gapCnt_r <= gapCnt_r + 1'b1;
	end

	always_ff @(posedge sys_clk)
	begin
		if (rxTake)
			rxBuf_r[rxPos[2:0]] <= uif.rxData;
	end

	always_ff @(posedge sys_clk)
	begin
		if (reset)
		begin
			rxIdx_r <= 4'h0;
			rxCrc_r <= CRC_INIT;
			reqPend_r <= 1'b0;
		end
		else
		begin
			reqPend_r <= 1'b0;
			if (rxTake)
			begin
				rxCrc_r <= rxCrcNxt;
				rxIdx_r <= rxLast ? 4'h0 : rxPos + 4'h1;
				// [R16] residue of zero means checksum good
				reqPend_r <= rxLast && (rxCrcNxt == CRC_GOOD);
			end
		end
	end

	// ------------------------------------------------------------
	// request decode
	// ------------------------------------------------------------
	wire [7:0] reqAddr = rxBuf_r[0];
	wire [7:0] reqFunc = rxBuf_r[1];
	wire [15:0] reqReg = {rxBuf_r[2], rxBuf_r[3]};
	wire [15:0] reqVal = {rxBuf_r[4], rxBuf_r[5]};
	wire regWritable = (reqReg == REG_MODE) || (reqReg == REG_CLEAR)
		|| (reqReg == REG_PULLUP) || (reqReg == REG_FILT_A) || (reqReg == REG_FILT_B);
	// [R16] another slave address gets no answer
	wire forUs = (reqAddr == SLAVE_ADDR);
	// [R01] read request with start and count
	wire readOk = (reqFunc == FUNC_READ) && (reqVal != 16'h0000) && (reqVal <= MAX_READ);
	wire writeOk = (reqFunc == FUNC_WRITE) && regWritable;
	wire accept = reqPend_r && forUs && (txState_r == TX_IDLE) && (readOk || writeOk);
	wire mbWr = accept && (reqFunc == FUNC_WRITE);

	// ------------------------------------------------------------
	// configuration registers
	// ------------------------------------------------------------
	// a serial write wins a same-cycle collision with the local port
	wire wrEn = mbWr || regWr;
	wire [15:0] wrAddr = mbWr ? reqReg : regAddr;
	wire [15:0] wrData = mbWr ? reqVal : regWdata;
	// [R06] clear key on the clear register
	wire doClear = wrEn && (wrAddr == REG_CLEAR) && (wrData == CLEAR_KEY);

	always_ff @(posedge sys_clk)
	begin
		if (reset)
		begin
			modeCfg_r <= 16'h0000;
			pullUp_r <= 16'h0000;
			filtA_r <= 16'h0000;
			filtB_r <= 16'h0000;
		end
		else
		begin
			// [R11] only the stored setting changes here
			if (nvRestore)
				modeCfg_r <= nvRestoreMode;
			else if (wrEn && (wrAddr == REG_MODE))
				modeCfg_r <= wrData;
			// [R12] pull-up control
			if (wrEn && (wrAddr == REG_PULLUP))
				pullUp_r <= wrData;
			// [R13] filter time settings
			if (wrEn && (wrAddr == REG_FILT_A))
				filtA_r <= wrData;
			if (wrEn && (wrAddr == REG_FILT_B))
				filtB_r <= wrData;
		end
	end

	// [R12] drive the pull-up enable
	assign pullUpEn = (pullUp_r == PULLUP_ON);

	// ------------------------------------------------------------
	// counting
	// ------------------------------------------------------------
	wire aRise = aFilt && !aPrev_r;
	wire bRise = bFilt && !bPrev_r;
	logic [COUNT_W-1:0] firstNxt;
	logic [COUNT_W-1:0] secondNxt;

	// [R10] [R14] mode 0: one step per rising edge of a, direction from b; mode 1: each channel counts up on its own rising edge
	always_comb
	begin
		firstNxt = countFirst_r;
		secondNxt = countSecond_r;
		if (activeMode_r)
		begin
			if (aRise)
				firstNxt = countFirst_r + 1'b1;
			if (bRise)
				secondNxt = countSecond_r + 1'b1;
		end
		else if (aRise)
			firstNxt = bFilt ? countFirst_r - 1'b1 : countFirst_r + 1'b1;
	end

	// [R07] [R08] full-rate edges into wrapping 32-bit counts
	always_ff @(posedge sys_clk)
	begin
		if (reset)
		begin
			aPrev_r <= 1'b0;
			bPrev_r <= 1'b0;
			activeMode_r <= 1'b0;
			countFirst_r <= '0;
			countSecond_r <= '0;
		end
		else
		begin
			aPrev_r <= aFilt;
			bPrev_r <= bFilt;
			// [R09] [R11] restart loads saved counts and mode
			if (nvRestore)
			begin
				activeMode_r <= (nvRestoreMode == MODE_IND);
				countFirst_r <= nvRestoreFirst;
				countSecond_r <= nvRestoreSecond;
			end
			else if (doClear)
			begin
				countFirst_r <= '0;
				countSecond_r <= '0;
			end
			else
			begin
				countFirst_r <= firstNxt;
				countSecond_r <= secondNxt;
			end
		end
	end

	// [R09] live values for the external save store
	assign nvMode = modeCfg_r;
	assign nvFirst = countFirst_r;
	assign nvSecond = countSecond_r;
	assign activeMode = activeMode_r;

	// ------------------------------------------------------------
	// local register port
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk)
	begin
		if (reset || !regRd)
			regRdata <= 16'h0000;
		else
			regRdata <= regRead(regAddr, 32'(countFirst_r), 32'(countSecond_r),
				modeCfg_r, pullUp_r, filtA_r, filtB_r);
	end

	// ------------------------------------------------------------
	// reply transmit
	// ------------------------------------------------------------
	wire [4:0] dataOff = txIdx_r - HDR_LEN;
	wire [15:0] txRegAddr = txStart_r + {12'h000, dataOff[4:1]};
	// snapshots keep a 32-bit value from tearing across two words
	wire [15:0] txWord = regRead(txRegAddr, 32'(snapFirst_r), 32'(snapSecond_r),
		modeCfg_r, pullUp_r, filtA_r, filtB_r);
	wire isCrcLo = (txIdx_r == txLen_r - CRC_LEN);
	wire isCrcHi = (txIdx_r == txLen_r - 5'h01);
	wire txLastByte = isCrcHi;
	logic [7:0] txByte;

	// [R02] read reply byte order
	always_comb
	begin
		if (txFunc_r == FUNC_WRITE)
			txByte = rxBuf_r[txIdx_r[2:0]];
		else if (txIdx_r == 5'h00)
			txByte = SLAVE_ADDR;
		else if (txIdx_r == 5'h01)
			txByte = txFunc_r;
		else if (txIdx_r == 5'h02)
			txByte = txCount_r;
		else if (isCrcLo)
			txByte = txCrc_r[7:0];
		else if (isCrcHi)
			txByte = txCrc_r[15:8];
		else
			txByte = dataOff[0] ? txWord[7:0] : txWord[15:8];
	end

	assign uif.txData = txByte;
	assign uif.txValid = (txState_r == TX_SEND);
	assign txEn = (txState_r != TX_IDLE);

	always_ff @(posedge sys_clk)
	begin
		if (reset)
		begin
			txState_r <= TX_IDLE;
			txIdx_r <= 5'h00;
			txLen_r <= 5'h00;
			txFunc_r <= 8'h00;
			txCount_r <= 8'h00;
			txStart_r <= 16'h0000;
			txCrc_r <= CRC_INIT;
			snapFirst_r <= '0;
			snapSecond_r <= '0;
		end
		else
		begin
			case (txState_r)
				TX_IDLE:
				begin
					if (accept)
					begin
						txState_r <= TX_SEND;
						txIdx_r <= 5'h00;
						txCrc_r <= CRC_INIT;
						txFunc_r <= reqFunc;
						txStart_r <= reqReg;
						txCount_r <= {reqVal[6:0], 1'b0};
						snapFirst_r <= countFirst_r;
						snapSecond_r <= countSecond_r;
						// [R05] echo length equals request length
						txLen_r <= (reqFunc == FUNC_WRITE) ? 5'(REQ_LEN)
							: HDR_LEN + {reqVal[3:0], 1'b0} + CRC_LEN;
					end
				end
				TX_SEND:
				begin
					if (uif.txReady)
					begin
						// the checksum bytes must not fold into the value they carry
						if (!isCrcLo && !isCrcHi)
							txCrc_r <= crc16Byte(txCrc_r, txByte);
						txIdx_r <= txIdx_r + 5'h01;
						if (txLastByte)
							txState_r <= TX_WAIT;
					end
				end
				TX_WAIT:
				begin
					if (!uif.txBusy)
						txState_r <= TX_IDLE;
				end
				default:
					txState_r <= TX_IDLE;
			endcase
		end
	end
endmodule

// *** ecms_top_monitor.sv ***
// concurrent checks on the port behaviour of the counter slave
`timescale 1ns/1ps
module ecms_top_monitor #(
	parameter int COUNT_W = 32
) (
	input wire logic sys_clk,
	input wire logic reset,
	input wire logic txd,
	input wire logic txEn,
	input wire logic pullUpEn,
	input wire logic activeMode,
	input wire logic [15:0] regAddr,
	input wire logic [15:0] regWdata,
	input wire logic regWr,
	input wire logic regRd,
	input wire logic [15:0] regRdata,
	input wire logic nvRestore,
	input wire logic [15:0] nvRestoreMode,
	input wire logic [COUNT_W-1:0] nvRestoreFirst,
	input wire logic [COUNT_W-1:0] nvRestoreSecond,
	input wire logic [15:0] nvMode,
	input wire logic [COUNT_W-1:0] nvFirst,
	input wire logic [COUNT_W-1:0] nvSecond
);
	import ecms_pkg::*;
	// ----
	// checks
	// ----
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (reset);
	wire modeWr = regWr && regAddr == REG_MODE && !nvRestore;
	wire clrWr = regWr && regAddr == REG_CLEAR && regWdata == CLEAR_KEY && !nvRestore;
	sequence startBit;
		!txd [*4];
	endsequence
	sequence modeRd;
		regRd && regAddr == REG_MODE;
	endsequence
	// restore and clear jump the count, so only plain steps are judged
	property step1;
		$changed(nvFirst) && !$past(nvRestore) && nvFirst != '0 |->
			nvFirst == $past(nvFirst) + 1'b1 || nvFirst + 1'b1 == $past(nvFirst);
	endproperty
	txd_idle_a: assert property (!txEn |-> txd)
		else $error("txd not idle with driver off");
	start_bit_a: assert property ($rose(txEn) |=> startBit)
		else $error("reply start bit missing");
	pullup_set_a: assert property (regWr && regAddr == REG_PULLUP |=> pullUpEn == ($past(regWdata) == PULLUP_ON))
		else $error("pull-up enable wrong after write");
	mode_hold_a: assert property (modeWr |=> $stable(activeMode) && nvMode == $past(regWdata))
		else $error("mode write acted live");
	restore_mode_a: assert property (nvRestore |=> activeMode == ($past(nvRestoreMode) == MODE_IND))
		else $error("mode wrong after restore");
	restore_count_a: assert property (nvRestore |=> nvFirst == $past(nvRestoreFirst) && nvSecond == $past(nvRestoreSecond))
		else $error("counts wrong after restore");
	clear_local_a: assert property (clrWr |=> nvFirst == '0 && nvSecond == '0)
		else $error("counts not cleared");
	mode_read_a: assert property (modeRd |=> regRdata == $past(nvMode))
		else $error("mode read back wrong");
	count_step_a: assert property (step1)
		else $error("count moved by more than one");
endmodule

bind ecms_top ecms_top_monitor #(.COUNT_W(COUNT_W)) mon (
	.sys_clk(sys_clk), .reset(reset), .txd(txd), .txEn(txEn), .pullUpEn(pullUpEn),
	.activeMode(activeMode), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
	.regRd(regRd), .regRdata(regRdata), .nvRestore(nvRestore), .nvRestoreMode(nvRestoreMode),
	.nvRestoreFirst(nvRestoreFirst), .nvRestoreSecond(nvRestoreSecond), .nvMode(nvMode),
	.nvFirst(nvFirst), .nvSecond(nvSecond)
);

// *** ecms_top_tb.sv ***
// self-checking bench for the counter slave
`timescale 1ns/1ps
module ecms_top_tb;
	import ecms_pkg::*;
	localparam int BD = 16;
	localparam int GAP = BD * 39;
	logic sys_clk = 1'b0;
	logic reset = 1'b1;
	logic rxd, txd, txEn, pullUpEn, activeMode, regWr, regRd, nvRestore, chA, chB;
	logic [15:0] regAddr, regWdata, regRdata, nvRestoreMode, nvMode, d;
	logic [31:0] nvRestoreFirst, nvRestoreSecond, nvFirst, nvSecond, v, w;
	logic [7:0] e [$];
	int n_errors = 0;
	int check_count = 0;
	int n;
	always #4 sys_clk = ~sys_clk;
	ecms_top #(.MS_CYCLES(8), .BAUD_DIV(BD), .GAP_CYCLES(GAP)) uut (
		.sys_clk(sys_clk), .reset(reset), .rxd(rxd), .txd(txd), .txEn(txEn),
		.firstCounterChannel(chA), .secondCounterChannel(chB), .pullUpEn(pullUpEn),
		.activeMode(activeMode), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
		.regRd(regRd), .regRdata(regRdata), .nvRestore(nvRestore), .nvRestoreMode(nvRestoreMode),
		.nvRestoreFirst(nvRestoreFirst), .nvRestoreSecond(nvRestoreSecond), .nvMode(nvMode),
		.nvFirst(nvFirst), .nvSecond(nvSecond));
	ecms_host #(.BAUD_DIV(BD)) host (.sys_clk(sys_clk), .rxd(rxd), .txd(txd), .txEn(txEn));
	task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
		check_count++;
		if (got !== ex)
		begin
			n_errors++;
			$display("mismatch %s expected %h seen %h", nm, ex, got);
		end
	endtask
	task automatic end_sim;
		$display("checks %0d mismatches %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic wr(input logic [15:0] a, input logic [15:0] dt);
		@(posedge sys_clk);
		regWr <= 1'b1;
		regAddr <= a;
		regWdata <= dt;
		@(posedge sys_clk);
		regWr <= 1'b0;
		#1;
	endtask
	task automatic rd(input logic [15:0] a, output logic [15:0] dt);
		@(posedge sys_clk);
		regRd <= 1'b1;
		regAddr <= a;
		@(posedge sys_clk);
		regRd <= 1'b0;
		#1;
		dt = regRdata;
	endtask
	// low word at the lower address, no latching between halves
	task automatic rdc(input logic [15:0] a, output logic [31:0] c);
		rd(a, c[15:0]);
		rd(a + 16'h0001, c[31:16]);
	endtask
	task automatic pulse(input logic [1:0] m, input int cnt, input int half);
		repeat (cnt)
		begin
			@(posedge sys_clk);
			{chB, chA} <= {chB, chA} | m;
			repeat (half) @(posedge sys_clk);
			{chB, chA} <= {chB, chA} & ~m;
			repeat (half - 1) @(posedge sys_clk);
		end
		repeat (8) @(posedge sys_clk);
	endtask
	// expected reply bytes: low word first, each word high byte first
	task automatic pushCount(input logic [31:0] x);
		e = {e, x[15:8], x[7:0], x[31:24], x[23:16]};
	endtask
	task automatic addCrc;
		logic [15:0] c;
		c = host.crcOf(e);
		e.push_back(c[7:0]);
		e.push_back(c[15:8]);
	endtask
	task automatic xfer(input logic [7:0] ad, input logic [7:0] fn, input logic [15:0] ra,
		input logic [15:0] rv, input bit bad);
		int i;
		host.got.delete();
		host.sendReq(ad, fn, ra, rv, bad);
		for (i = 0; i < 100 && txEn !== 1'b1; i++)
			@(posedge sys_clk);
		for (i = 0; i < 3000 && txEn !== 1'b0; i++)
			@(posedge sys_clk);
		if (i == 3000)
		begin
			chk("reply end", 1, 0);
			end_sim();
		end
		repeat (GAP + 20) @(posedge sys_clk);
		chk("reply length", e.size(), host.got.size());
		foreach (e[k])
			chk("reply byte", e[k], host.got[k]);
	endtask
	initial
	begin
		{regWr, regRd, nvRestore, chA, chB} = '0;
		{regAddr, regWdata, nvRestoreMode} = '0;
		{nvRestoreFirst, nvRestoreSecond} = '0;
		void'($urandom(73));
		repeat (12) @(posedge sys_clk);
		reset <= 1'b0;
		@(posedge sys_clk);
		#1;
		chk("txd idle", 1, txd);
		chk("mode after reset", 0, activeMode);
		$display("test reset done");
		wr(REG_PULLUP, PULLUP_ON);
		chk("pull-up on", 1, pullUpEn);
		wr(REG_PULLUP, 16'h0002);
		chk("pull-up off", 0, pullUpEn);
		rd(REG_PULLUP, d);
		chk("pull-up read", 16'h0002, d);
		rd(16'h0099, d);
		chk("unmapped read", 0, d);
		$display("test registers done");
		n = 1 + $urandom_range(20);
		pulse(2'b01, n, 4);
		pulse(2'b01, 2, 1250);
		chB <= 1'b1;
		pulse(2'b01, n + 5, 4);
		pulse(2'b10, 3, 4);
		rdc(REG_ENC_LO, v);
		chk("signed count", 32'hfffffffd, v);
		e = {SLAVE_ADDR, FUNC_READ, 8'h04};
		pushCount(32'hfffffffd);
		addCrc();
		xfer(SLAVE_ADDR, FUNC_READ, REG_ENC_LO, 16'h0002, 0);
		e.delete();
		xfer(8'h02, FUNC_READ, REG_ENC_LO, 16'h0002, 0);
		xfer(SLAVE_ADDR, FUNC_READ, REG_ENC_LO, 16'h0002, 1);
		xfer(SLAVE_ADDR, FUNC_READ, REG_ENC_LO, 16'h0000, 0);
		e = {SLAVE_ADDR, FUNC_WRITE, 8'h00, 8'h43, 8'h00, 8'h0a};
		addCrc();
		xfer(SLAVE_ADDR, FUNC_WRITE, REG_CLEAR, CLEAR_KEY, 0);
		rdc(REG_ENC_LO, v);
		chk("cleared count", 0, v);
		$display("test encoder mode done");
		wr(REG_MODE, MODE_IND);
		chk("mode not live", 0, activeMode);
		chk("mode stored", MODE_IND, nvMode);
		rd(REG_MODE, d);
		chk("mode read", MODE_IND, d);
		v = $urandom();
		@(posedge sys_clk);
		nvRestore <= 1'b1;
		nvRestoreMode <= nvMode;
		nvRestoreFirst <= v;
		nvRestoreSecond <= 32'hfffffffe;
		@(posedge sys_clk);
		nvRestore <= 1'b0;
		#1;
		chk("mode after restart", 1, activeMode);
		chk("restored count", v, nvFirst);
		pulse(2'b01, 3, 4);
		pulse(2'b10, 3, 4);
		e = {SLAVE_ADDR, FUNC_READ, 8'h08};
		pushCount(v + 32'd3);
		pushCount(32'h00000001);
		addCrc();
		xfer(SLAVE_ADDR, FUNC_READ, REG_CHA_LO, 16'h0004, 0);
		$display("test counter mode done");
		n = 2 + $urandom_range(2);
		wr(REG_FILT_A, 16'(n));
		rd(REG_FILT_A, d);
		chk("filter read", n, d);
		wr(REG_FILT_B, 16'(n + 1));
		rd(REG_FILT_B, d);
		chk("filter b read", n + 1, d);
		pulse(2'b01, 1, 5);
		pulse(2'b01, 2, (n + 2) * 8);
		rdc(REG_CHA_LO, w);
		chk("filtered count", v + 32'd5, w);
		wr(REG_CLEAR, CLEAR_KEY);
		chk("local clear", 0, nvSecond);
		chk("local clear first", 0, nvFirst);
		$display("test filter and clear done");
		end_sim();
	end
endmodule

// *** ecms_uart.sv ***
// 8n1 serial byte receiver and transmitter
`timescale 1ns/1ps
module ecms_uart #(
	parameter int BAUD_DIV = ecms_pkg::BAUD_DIV
) (
	input wire logic sys_clk,
	input wire logic reset,
	input wire logic rxd,
	output logic txd,
	ecms_uart_if.uart bus
);
	import ecms_pkg::*;
	localparam int CW = $clog2(BAUD_DIV + 1);
	localparam logic [CW-1:0] DIV_M1 = CW'(BAUD_DIV - 1);
	localparam logic [CW-1:0] DIV_HALF = CW'(BAUD_DIV / 2);
	localparam logic [3:0] FRAME_BITS = 4'ha;
	localparam logic [3:0] STOP_BIT = 4'h9;
	logic [CW-1:0] rxCnt_r;
	logic [3:0] rxBit_r;
	logic [7:0] rxSh_r;
	logic rxAct_r;
	logic [CW-1:0] txCnt_r;
	logic [3:0] txBit_r;
	logic [9:0] txSh_r;

	assign bus.txReady = (txBit_r == 4'h0);
	assign bus.txBusy = !bus.txReady;
	assign txd = txSh_r[0];

	// sample mid-bit; a start bit high at its middle is a glitch
	always_ff @(posedge sys_clk)
	begin
		if (reset)
		begin
			rxAct_r <= 1'b0;
			rxCnt_r <= '0;
			rxBit_r <= 4'h0;
			rxSh_r <= 8'h00;
			bus.rxValid <= 1'b0;
			bus.rxData <= 8'h00;
		end
		else
		begin
			bus.rxValid <= 1'b0;
			if (!rxAct_r)
			begin
				rxAct_r <= !rxd;
				rxCnt_r <= DIV_HALF;
				rxBit_r <= 4'h0;
			end
			else if (rxCnt_r != '0)
				rxCnt_r <= rxCnt_r - 1'b1;
			else
			begin
				rxCnt_r <= DIV_M1;
				rxBit_r <= rxBit_r + 4'h1;
				if (rxBit_r == STOP_BIT)
				begin
					rxAct_r <= 1'b0;
					bus.rxValid <= rxd;
					bus.rxData <= rxSh_r;
				end
				else if (rxBit_r != 4'h0)
					rxSh_r <= {rxd, rxSh_r[7:1]};
				else if (rxd)
					rxAct_r <= 1'b0;
			end
		end
	end

	always_ff @(posedge sys_clk)
	begin
		if (reset)
		begin
			txSh_r <= 10'h3ff;
			txBit_r <= 4'h0;
			txCnt_r <= '0;
		end
		else if (bus.txValid && bus.txReady)
		begin
			txSh_r <= {1'b1, bus.txData, 1'b0};
			txBit_r <= FRAME_BITS;
			txCnt_r <= DIV_M1;
		end
		else if (txBit_r != 4'h0)
		begin
			if (txCnt_r != '0)
				txCnt_r <= txCnt_r - 1'b1;
			else
			begin
				txCnt_r <= DIV_M1;
				txSh_r <= {1'b1, txSh_r[9:1]};
				txBit_r <= txBit_r - 4'h1;
			end
		end
	end
endmodule

// *** ecms_uart_if.sv ***
// byte stream carrier between the frame engine and the serial port
`timescale 1ns/1ps
interface ecms_uart_if;
	logic [7:0] txData;
	logic txValid;
	logic txReady;
	logic txBusy;
	logic [7:0] rxData;
	logic rxValid;
	modport uart(input txData, txValid, output txReady, txBusy, rxData, rxValid);
	modport host(output txData, txValid, input txReady, txBusy, rxData, rxValid);
endinterface
